/* psc_power_ctl.v */
// Function
// - sleep or idle entered only by power-save instruction, operand picks mode
// - sleep stops system clock, halts code, turns oscillator off
// - idle halts cpu; peripherals keep running unless disabled
// - wake on enabled interrupt, any reset, or watchdog time-out
// - clock failure monitor inactive during sleep
// - low-power rc clock runs in sleep when watchdog enabled
// - watchdog cleared just before sleep entry
// - watchdog cleared on idle entry
// - sleep disables system-clocked peripherals; external-clock ones may run (code stops every module clock in sleep)
// - wake from sleep resumes with clock source active at entry
// - system clock source stays active in idle
// - idle keeps rc clock running if watchdog or monitor enabled
// - idle wake reapplies cpu clock at once
// - interrupt during instruction deferred until entry done, then wakes
// - doze slows only cpu clock; peripheral clock unchanged, aligned
// - doze enabled by divisor bit 11
// - divisor bits 14:12 pick ratio 1:1 to 1:128, default 1:1
// - return-on-interrupt set restores full speed; clear ignores interrupts
// - doze enable cleared by hardware on interrupt with return bit set
// - module disable stops its clocks and blocks its register access
// - module enabled only when present and bit clear; reset clear
// - disable bit change takes effect one instruction cycle later (code: mod_clk_en and mod_reg_en change three clocks after md_wr)
// - new oscillator field write requests clock switch unless locked
`include "psc_map.vh"
module psc_power_ctl #(
  parameter NUM_MOD = 8,               // peripheral count
  parameter [NUM_MOD-1:0] MOD_PRESENT = {NUM_MOD{1'b1}} // variant fit
) (
  input  wire               clock,          // system clock
  input  wire               rst,            // sync reset
  input  wire               pwrsave_exec,   // power-save instruction pulse
  input  wire               pwrsave_idle,   // operand: 1 idle, 0 sleep
  input  wire               irq_pending,    // enabled interrupt, same domain
  input  wire               watchdog_timeout, // watchdog time-out
  input  wire               watchdog_enable,  // watchdog enabled
  input  wire               monitor_enable,   // monitor enabled
  input  wire               cfg_locked,     // clock config locked
  input  wire               div_wr,         // divisor register write
  input  wire [15:0]        div_wdata,      // divisor write data
  input  wire               osc_wr,         // osc control high write
  input  wire [15:0]        osc_wdata,      // osc control write data
  input  wire               md_wr,          // module disable write
  input  wire [NUM_MOD-1:0] md_wdata,       // module disable data
  output reg  [15:0]        div_rdata,      // divisor register readback
  output reg  [2:0]         osc_select,     // selected new oscillator
  output reg                osc_switch_req, // clock switch request pulse
  output reg                sys_clk_on,     // system clock source on
  output reg                cpu_clk_en,     // cpu clock enable
  output reg                rc_clock_on,    // rc clock running
  output reg                monitor_active, // monitor running
  output reg                watchdog_clear, // watchdog clear pulse
  output reg                in_sleep,       // sleep state
  output reg                in_idle,        // idle state
  output reg  [NUM_MOD-1:0] mod_clk_en,     // per-module clock enable
  output reg  [NUM_MOD-1:0] mod_reg_en      // per-module register access
);
  ////////////////////////////////////////////////////////////////
  localparam [2:0] ST_RUN   = 3'h1;
  localparam [2:0] ST_SLEEP = 3'h2;
  localparam [2:0] ST_IDLE  = 3'h4;

  reg  [2:0]         state;
  reg  [2:0]         next_state;
  reg                ret_on_irq;
  reg                slow_en;
  reg  [2:0]         ratio;
  reg  [NUM_MOD-1:0] md_bits;
  reg  [NUM_MOD-1:0] md_stage;
  reg  [2:0]         sleep_src;
  wire               doze_tick;
  wire               wake;

  assign wake = irq_pending | watchdog_timeout;

  ////////////////////////////////////////////////////////////////
  // instruction entry
  always @* begin
    next_state = state;
    case (state)
      ST_RUN: begin
        if (pwrsave_exec)
          next_state = (pwrsave_idle == `PSC_OP_IDLE) ? ST_IDLE : ST_SLEEP;
      end
      ST_SLEEP: begin
        if (wake)
          next_state = ST_RUN;
      end
      ST_IDLE: begin
        if (wake)
          next_state = ST_RUN;
      end
      default: next_state = ST_RUN;
    endcase
  end

  always @(posedge clock) begin
    if (rst)
      state <= ST_RUN;
    else
      state <= next_state;
  end

  ////////////////////////////////////////////////////////////////
  // state outputs, registered
  always @(posedge clock) begin
    if (rst) begin
      in_sleep    <= 1'b0;
      in_idle     <= 1'b0;
      sys_clk_on  <= 1'b1;
      rc_clock_on    <= 1'b0;
      monitor_active <= 1'b0;
      watchdog_clear <= 1'b0;
      sleep_src   <= `PSC_OSC_RESET;
    end else begin
      in_sleep <= (next_state == ST_SLEEP);
      in_idle  <= (next_state == ST_IDLE);
      // sleep stops system source, idle keeps it
      sys_clk_on <= (next_state != ST_SLEEP);
      monitor_active <= monitor_enable & (next_state != ST_SLEEP);
      // rc clock in sleep, rc clock in idle
      rc_clock_on <= (next_state == ST_SLEEP) ? watchdog_enable :
                     (watchdog_enable | monitor_enable);
      watchdog_clear <= (state == ST_RUN) & pwrsave_exec & watchdog_enable;
      if ((state == ST_RUN) && pwrsave_exec)
        sleep_src <= osc_select;
    end
  end

  ////////////////////////////////////////////////////////////////
  // clock divisor register
  always @(posedge clock) begin
    if (rst) begin
      ret_on_irq <= 1'b0;
      slow_en    <= 1'b0;
      ratio      <= `PSC_RATIO_RESET;
    end else begin
      if (div_wr) begin
        ret_on_irq <= div_wdata[`PSC_DIV_RET_BIT];
        ratio <= div_wdata[`PSC_DIV_RATIO_HI:`PSC_DIV_RATIO_LO];
        slow_en <= div_wdata[`PSC_DIV_SLOW_BIT];
      end
      if (ret_on_irq && irq_pending)
        slow_en <= 1'b0;
    end
  end

  always @(posedge clock) begin
    if (rst)
      div_rdata <= `PSC_DIV_RESET;
    else begin
      div_rdata <= `PSC_DIV_RESET;
      div_rdata[`PSC_DIV_RET_BIT] <= ret_on_irq;
      div_rdata[`PSC_DIV_RATIO_HI:`PSC_DIV_RATIO_LO] <= ratio;
      div_rdata[`PSC_DIV_SLOW_BIT] <= slow_en;
    end
  end

  ////////////////////////////////////////////////////////////////
  // divided enable from system clock
  psc_doze_div u_doze (
    .clock  (clock),
    .rst    (rst),
    .active (slow_en & ~(ret_on_irq & irq_pending)),
    .ratio  (ratio),
    .tick   (doze_tick)
  );

  // only cpu slowed; roi interrupt gives full speed
  // cpu halted in idle, back the cycle after wake is seen
  always @* begin
    case (state)
      ST_RUN:  cpu_clk_en = doze_tick | (ret_on_irq & irq_pending);
      default: cpu_clk_en = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////
  // oscillator selection
  always @(posedge clock) begin
    if (rst) begin
      osc_select     <= `PSC_OSC_RESET;
      osc_switch_req <= 1'b0;
    end else begin
      osc_switch_req <= osc_wr & ~cfg_locked;
      if (osc_wr && !cfg_locked)
        osc_select <= osc_wdata[`PSC_OSC_NEW_HI:`PSC_OSC_NEW_LO];
      // restore entry source on sleep wake
      else if (state == ST_SLEEP && next_state == ST_RUN)
        osc_select <= sleep_src;
    end
  end

  ////////////////////////////////////////////////////////////////
  // module disable
  always @(posedge clock) begin
    if (rst) begin
      md_bits  <= {NUM_MOD{1'b0}};
      md_stage <= {NUM_MOD{1'b0}};
    end else begin
      if (md_wr)
        md_bits <= md_wdata;
      md_stage <= md_bits;
    end
  end

  always @(posedge clock) begin
    if (rst) begin
      mod_clk_en <= {NUM_MOD{1'b0}};
      mod_reg_en <= {NUM_MOD{1'b0}};
    end else begin
      // clocks and registers gated; no clocks in sleep, registers still open
      mod_clk_en <= ~md_stage & MOD_PRESENT & {NUM_MOD{next_state != ST_SLEEP}};
      mod_reg_en <= ~md_stage & MOD_PRESENT;
    end
  end
endmodule // psc_power_ctl

/* psc_map.vh */
`ifndef PSC_MAP_VH
`define PSC_MAP_VH
// clock divisor register fields
`define PSC_DIV_RET_BIT      15
`define PSC_DIV_RATIO_HI     14
`define PSC_DIV_RATIO_LO     12
`define PSC_DIV_SLOW_BIT     11
`define PSC_DIV_RESET        16'h0000
`define PSC_RATIO_RESET      3'h0
// oscillator control register fields
`define PSC_OSC_NEW_HI       10
`define PSC_OSC_NEW_LO       8
`define PSC_OSC_RESET        3'h0
// power-save operand encodings
`define PSC_OP_SLEEP         1'b0
`define PSC_OP_IDLE          1'b1
// module disable timing: one instruction cycle
`define PSC_MD_DELAY         2'h1
`define PSC_RATIO_W          3
`endif

/* psc_doze_div.v */
`include "psc_map.vh"
// periodic cpu clock enable, one pulse every 2^ratio system cycles
module psc_doze_div (
  input  wire       clock,     // system clock
  input  wire       rst,       // sync reset
  input  wire       active,    // doze running
  input  wire [2:0] ratio,     // log2 of divide
  output reg        tick       // cpu enable pulse
);
  reg [6:0] count;
  wire [6:0] limit;
  assign limit = 7'h7f >> (3'h7 - ratio);
  always @(posedge clock) begin
    if (rst) begin
      count <= 7'h00;
      tick  <= 1'b0;
    end else if (!active) begin
      count <= 7'h00;
      tick  <= 1'b1;
    end else if (count >= limit) begin
      count <= 7'h00;
      tick  <= 1'b1;
    end else begin
      count <= count + 7'h01;
      tick  <= 1'b0;
    end
  end
endmodule // psc_doze_div

/* psc_cpu_model.sv */
module psc_cpu_model (
  input  wire logic       clock,            // system clock
  input  wire logic       go,               // issue power-save instruction
  input  wire logic       go_idle,          // operand for go
  input  wire logic [3:0] lag,              // irq delay after exec
  input  wire logic       raise,            // interrupt now
  input  wire logic       irq_clr,          // handler entered
  output logic            pwrsave_exec = 0, // instruction pulse
  output logic            pwrsave_idle = 0, // operand
  output logic            irq_pending = 0   // enabled interrupt
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [4:0] cnt = 5'h00;
  ////////////////////////////////////////
  always @(posedge clock) begin
    pwrsave_exec <= go;
    // operand only means something beside exec
    pwrsave_idle <= go ? go_idle : ~pwrsave_idle;
    cnt <= go ? {1'b1, lag} : cnt - {4'h0, cnt[4] && cnt[3:0] != 4'h0};
    irq_pending <= !irq_clr && (irq_pending || raise || (go && lag == 4'h0) || cnt == 5'h11);
  end
endmodule // psc_cpu_model

/* psc_ctl_properties.sv */
module psc_ctl_properties #(
  parameter NUM_MOD = 8 // peripheral count
) (
  input wire logic clock, rst, pwrsave_exec, pwrsave_idle, irq_pending, watchdog_timeout,
  input wire logic watchdog_enable, monitor_enable, cfg_locked, osc_wr, md_wr, osc_switch_req,
  input wire logic sys_clk_on, cpu_clk_en, rc_clock_on, monitor_active, watchdog_clear,
  input wire logic in_sleep, in_idle,
  input wire logic [15:0] osc_wdata, div_rdata,
  input wire logic [NUM_MOD-1:0] md_wdata, mod_reg_en,
  input wire logic [2:0] osc_select
);
  timeunit 1ns;
  timeprecision 100ps;
  wire run = !in_sleep && !in_idle;
  wire [2:0] new_sel = osc_wdata[10:8];
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  ////////////////////////////////////////
  sleep_entry_a: assert property (
    pwrsave_exec && !pwrsave_idle && run |=> in_sleep && !sys_clk_on && !cpu_clk_en) else $error("sleep entry");
  idle_entry_a: assert property (
    pwrsave_exec && pwrsave_idle && run |=> in_idle && sys_clk_on
    && (watchdog_clear == $past(watchdog_enable))) else $error("idle entry");
  sleep_wdt_a: assert property (
    pwrsave_exec && !pwrsave_idle && run |=> watchdog_clear == $past(watchdog_enable))
    else $error("watchdog clear wrong");
  wake_a: assert property (
    !run && (irq_pending || watchdog_timeout) |=> run && sys_clk_on) else $error("no wake");
  monitor_off_a: assert property (
    in_sleep |-> !monitor_active) else $error("monitor on in sleep");
  rc_clock_a: assert property (
    (in_sleep && watchdog_enable || in_idle && (watchdog_enable || monitor_enable))
    && $stable({watchdog_enable, monitor_enable}) |-> rc_clock_on) else $error("rc clock off");
  md_delay_a: assert property (
    md_wr |-> ##3 mod_reg_en == ~$past(md_wdata, 3)) else $error("module disable");
  roi_wake_a: assert property (
    div_rdata[15] && div_rdata[11] && irq_pending && run |-> cpu_clk_en ##1 !div_rdata[11]) else $error("roi");
  osc_req_a: assert property (
    osc_wr && !cfg_locked |=> osc_switch_req && osc_select == $past(new_sel)) else $error("osc select");
endmodule // psc_ctl_properties

/* testbench.sv */
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int NUM_MOD = 8;
  logic clock = 0, rst = 1, go = 0, go_idle = 0, raise = 0, irq_clr = 0, watchdog_timeout = 0;
  logic watchdog_enable = 1, monitor_enable = 0, cfg_locked = 0, div_wr = 0, osc_wr = 0;
  logic md_wr = 0;
  logic [3:0] lag = 0;
  logic [15:0] div_wdata = 0, osc_wdata = 0, div_rdata;
  logic [7:0] md_wdata = 0, mod_clk_en, mod_reg_en;
  logic pwrsave_exec, pwrsave_idle, irq_pending, osc_switch_req, sys_clk_on, cpu_clk_en;
  logic rc_clock_on, monitor_active, watchdog_clear, in_sleep, in_idle;
  logic [2:0] osc_select;
  logic [31:0] seed = 32'hd22dff1a;
  int miscompares = 0, samples_checked = 0, n, k;
  psc_cpu_model i_cpu (.clock, .go, .go_idle, .lag, .raise, .irq_clr, .pwrsave_exec,
    .pwrsave_idle, .irq_pending);
  psc_power_ctl #(.NUM_MOD(NUM_MOD)) i_dut (.clock, .rst, .pwrsave_exec, .pwrsave_idle,
    .irq_pending, .watchdog_timeout, .watchdog_enable, .monitor_enable, .cfg_locked, .div_wr,
    .div_wdata, .osc_wr, .osc_wdata, .md_wr, .md_wdata, .div_rdata, .osc_select,
    .osc_switch_req, .sys_clk_on, .cpu_clk_en, .rc_clock_on, .monitor_active,
    .watchdog_clear, .in_sleep, .in_idle,
    .mod_clk_en, .mod_reg_en);
  initial forever #12.5 clock = ~clock;
  ////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [15:0] div_word(input logic ri, input logic [2:0] r, input logic dz);
    return {ri, r, dz, 11'h000};
  endfunction
  task automatic finish_test;
    $display("compares %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("FAIL %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int c);
    repeat (c) @(posedge clock);
    #1;
  endtask
  task automatic wait_state(input logic want);
    for (n = 0; n < 64 && (in_sleep | in_idle) !== want; n++) tick(1);
    if (n == 64) begin
      miscompares++;
      finish_test();
    end
  endtask
  task automatic enter(input logic idle, input logic [3:0] l);
    @(posedge clock);
    {go, go_idle, lag} <= {1'b1, idle, l};
    @(posedge clock);
    go <= 1'b0;
    wait_state(1'b1);
  endtask
  task automatic wr(input int w, input logic [15:0] d);
    @(posedge clock);
    {div_wr, osc_wr, md_wr} <= {w == 0, w == 1, w == 2};
    {div_wdata, osc_wdata, md_wdata} <= {d, d, d[7:0]};
    @(posedge clock);
    {div_wr, osc_wr, md_wr} <= 3'b000;
    tick(2);
  endtask
  task automatic irq(input logic up);
    @(posedge clock);
    {raise, irq_clr} <= {up, !up};
    @(posedge clock);
    {raise, irq_clr} <= 2'b00;
  endtask
  ////////////////////////////////////////
  initial begin
    repeat (20) @(posedge clock);
    rst <= 1'b0;
    tick(2);
    chk(div_rdata, 16'h0000);
    chk(mod_reg_en, 8'hff);
    seed = lfsr(seed);
    wr(1, seed[15:0]);
    chk(osc_select, seed[10:8]);
    @(posedge clock);
    cfg_locked <= 1'b1;
    wr(1, ~seed[15:0]);
    chk(osc_select, seed[10:8]);
    enter(1'b0, 4'h9);
    chk({sys_clk_on, rc_clock_on, monitor_active, mod_clk_en}, 11'h200);
    wait_state(1'b0);
    chk(osc_select, seed[10:8]);
    irq(1'b0);
    enter(1'b1, 4'h0);
    chk({sys_clk_on, cpu_clk_en, watchdog_clear, mod_clk_en}, 11'h5ff);
    tick(1);
    chk(in_idle, 1'b0);
    irq(1'b0);
    @(posedge clock);
    watchdog_enable <= 1'b0;
    monitor_enable <= 1'b1;
    enter(1'b0, 4'hf);
    chk({rc_clock_on, monitor_active, watchdog_clear}, 3'b000);
    @(posedge clock);
    watchdog_timeout <= 1'b1;
    @(posedge clock);
    watchdog_timeout <= 1'b0;
    tick(1);
    chk(in_sleep, 1'b0);
    tick(16);
    irq(1'b0);
    for (int r = 0; r < 8; r++) begin
      wr(0, div_word(1'b0, r[2:0], 1'b1));
      k = 0;
      repeat (256) begin
        tick(1);
        k += cpu_clk_en;
      end
      chk(k[15:0], 16'd256 >> r);
    end
    wr(0, div_word(1'b0, 3'h2, 1'b1));
    irq(1'b1);
    tick(3);
    chk(div_rdata, div_word(1'b0, 3'h2, 1'b1));
    wr(0, div_word(1'b1, 3'h7, 1'b1));
    chk(div_rdata, div_word(1'b1, 3'h7, 1'b0));
    irq(1'b0);
    repeat (4) begin
      seed = lfsr(seed);
      wr(2, seed[15:0]);
      tick(1);
      chk({mod_reg_en, mod_clk_en}, ~{2{seed[7:0]}});
    end
    finish_test();
  end
endmodule // testbench

bind psc_power_ctl psc_ctl_properties #(.NUM_MOD(NUM_MOD)) i_chk (.clock, .rst, .pwrsave_exec,
  .pwrsave_idle, .irq_pending, .watchdog_timeout, .watchdog_enable, .monitor_enable,
  .cfg_locked, .osc_wr, .md_wr, .osc_switch_req, .sys_clk_on, .cpu_clk_en, .rc_clock_on,
  .monitor_active, .watchdog_clear,
  .in_sleep, .in_idle, .osc_wdata, .div_rdata, .md_wdata, .mod_reg_en, .osc_select);
